// [design/smar_pkg.sv]
// shared offsets, encoders and state types of the module attribute store
package smar_pkg;

	// ************************************************************
	// byte offsets within the description table
	// ************************************************************
	localparam logic [7:0] OFS_BURST      = 8'h10;
	localparam logic [7:0] OFS_BANKS      = 8'h11;
	localparam logic [7:0] OFS_COL_LAT    = 8'h12;
	localparam logic [7:0] OFS_CS_LAT     = 8'h13;
	localparam logic [7:0] OFS_WE_LAT     = 8'h14;
	localparam logic [7:0] OFS_MODULE     = 8'h15;
	localparam logic [7:0] OFS_COMPONENT  = 8'h16;
	localparam logic [7:0] OFS_TCK2       = 8'h17;
	localparam logic [7:0] OFS_TAC2       = 8'h18;
	localparam logic [7:0] OFS_TCK3       = 8'h19;
	localparam logic [7:0] OFS_TAC3       = 8'h1A;
	localparam logic [7:0] OFS_TRP        = 8'h1B;
	localparam logic [7:0] OFS_TRRD       = 8'h1C;
	localparam logic [7:0] OFS_TRCD       = 8'h1D;
	localparam int         BYTE_COUNT     = 14;
	localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

	// ************************************************************
	// serial link constants and field limits
	// ************************************************************
	localparam logic [3:0] DEV_TYPE       = 4'hA;
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	localparam int         TENTH_NS_MIN   = 4;
	localparam int         TENTH_NS_MAX   = 15;
	localparam int         TENTH_MAX      = 9;
	localparam int         ROLLUP_LO      = 16;
	localparam int         ROLLUP_HI      = 18;
	localparam int         ROLLUP_BASE    = 15;
	localparam int         QTR_NS_MAX     = 63;
	localparam int         QTR_MAX        = 3;
	localparam int         NS_MAX         = 255;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX   = 3'h1,
		ST_ACK  = 3'h2,
		ST_TX   = 3'h3,
		ST_MACK = 3'h4
	} smar_state_t;

	typedef enum logic [1:0] {
		K_ADDR = 2'h0,
		K_WORD = 2'h1,
		K_DATA = 2'h2
	} smar_kind_t;

	// ************************************************************
	// byte encoders
	// ************************************************************
	function automatic logic [7:0] enc_burst(input logic [3:0] lens, input logic page);
		enc_burst = {page, 3'h0, lens};
	endfunction : enc_burst

	function automatic logic [7:0] enc_mask7(input logic [6:0] mask);
		enc_mask7 = {1'h0, mask};
	endfunction : enc_mask7

	function automatic logic [7:0] enc_devattr(input logic [3:0] feat, input logic up5, input logic lo5);
		enc_devattr = {2'h0, up5, lo5, feat};
	endfunction : enc_devattr

	// 16 to 18 ns fold onto codes 1 to 3; 1 to 3 ns cannot be stored
	function automatic logic [7:0] enc_tenth(input int ns, input int tenths);
		logic [3:0] hi;
		logic [3:0] lo;
		hi = 4'h0;
		if (ns >= ROLLUP_LO && ns <= ROLLUP_HI) begin
			hi = 4'(ns - ROLLUP_BASE);
		end else if (ns >= TENTH_NS_MIN && ns <= TENTH_NS_MAX) begin
			hi = 4'(ns);
		end
		lo = (tenths >= 0 && tenths <= TENTH_MAX) ? 4'(tenths) : 4'h0;
		enc_tenth = {hi, lo};
	endfunction : enc_tenth

	function automatic logic [7:0] enc_quarter(input int ns, input int qtr);
		logic [5:0] hi;
		logic [1:0] lo;
		hi = (ns >= 1 && ns <= QTR_NS_MAX) ? 6'(ns) : 6'h00;
		lo = (qtr >= 0 && qtr <= QTR_MAX) ? 2'(qtr) : 2'h0;
		enc_quarter = {hi, lo};
	endfunction : enc_quarter

	function automatic logic [7:0] enc_ns(input int ns);
		enc_ns = (ns >= 1 && ns <= NS_MAX) ? 8'(ns) : 8'h00;
	endfunction : enc_ns

endpackage : smar_pkg

// [design/smar_rom_if.sv]
// lookup port between the serial front end and the attribute store
`timescale 1ns/10ps
interface smar_rom_if;
	logic [7:0] offset;
	logic [7:0] data;
	logic       hit;

	modport reader (output offset, input data, input hit);
	modport store  (input offset, output data, output hit);
endinterface : smar_rom_if

// [design/smar_sync.sv]
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module smar_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule : smar_sync

// [design/smar_rom.sv]
// attribute byte store, flip-flops fixed at reset, lookup by offset
`timescale 1ns/10ps
module smar_rom import smar_pkg::*; #(
	parameter int               DEPTH = BYTE_COUNT,
	parameter logic [7:0]       BASE  = OFS_BURST,
	parameter logic [DEPTH*8-1:0] INIT = '0
) (
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	smar_rom_if.store   rom
);
	localparam int IW = $clog2(DEPTH);

	logic [7:0]    mem_q [DEPTH];
	logic [7:0]    rel_w;
	logic [IW-1:0] idx_w;

	// no write port exists: host writes can never alter a byte
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= INIT[i*8 +: 8];
			end
		end
	end

	assign rel_w    = rom.offset - BASE;
	assign idx_w    = rel_w[IW-1:0];
	assign rom.hit  = (rom.offset >= BASE) && (rel_w < 8'(DEPTH));
	assign rom.data = rom.hit ? mem_q[idx_w] : UNMAPPED_VALUE;
endmodule : smar_rom

// [design/smar_top.sv]
// serial-read module attribute store: two-wire slave front end and byte table
//
// Operation
// R1: a burst-support bit is one exactly when that burst length is supported
// R2: burst bits 0..3 give lengths 1,2,4,8, bit 7 full page, bits 6..4 zero
// R3: bank byte holds per-component internal bank count in binary; zero is reserved
// R4: column-latency bit n-1 is set when latency n, 1 to 7, is supported
// R5: chip-select latency bit n is set when latency n, 0 to 6, is acceptable
// R6: write-enable latency bit n is set when latency n, 0 to 6, is supported
// R7: module byte bits 0..2 flag buffered, registered address/control and on-card PLL
// R8: module byte bits 3..6 flag buffered, registered byte masks, differential clock, redundancy
// R9: component byte bits 0..3 flag precharge features; bits 7 and 6 zero
// R10: component bits 5 and 4 give upper and lower supply tolerance, one means five percent
// R11: second-latency clock period byte is whole nanoseconds high, tenths low
// R12: second-latency access time byte uses the same nanosecond and tenths split
// R13: in second-latency timings codes 1 to 3 stand for 16 to 18 ns
// R14: third-latency clock period is six bits nanoseconds plus two bits quarters
// R15: third-latency access time uses the same nanoseconds plus quarters format
// R16: precharge-to-activate minimum is whole nanoseconds 1 to 255, zero undefined
// R17: activate-to-activate minimum is whole nanoseconds 1 to 255, zero undefined
// R18: row-to-column delay minimum is whole nanoseconds 1 to 255, zero undefined
// R19: host applies the tolerance flags as the range where stored timings hold
// R20: every byte is returned unchanged and host writes never alter it
`timescale 1ns/10ps
module smar_top import smar_pkg::*; #(
	parameter logic [3:0] BURST_LENS = 4'hF,
	parameter logic       BURST_PAGE = 1'h1,
	parameter int         DEV_BANKS  = 4,
	parameter logic [6:0] COL_LAT    = 7'h06,
	parameter logic [6:0] CS_LAT     = 7'h01,
	parameter logic [6:0] WE_LAT     = 7'h01,
	parameter logic [6:0] MOD_FLAGS  = 7'h00,
	parameter logic [3:0] DEV_FLAGS  = 4'hE,
	parameter logic       UP_TOL_5   = 1'h0,
	parameter logic       LO_TOL_5   = 1'h0,
	parameter int         TCK2_NS    = 15,
	parameter int         TCK2_TENTH = 0,
	parameter int         TAC2_NS    = 9,
	parameter int         TAC2_TENTH = 0,
	parameter int         TCK3_NS    = 0,
	parameter int         TCK3_QTR   = 0,
	parameter int         TAC3_NS    = 0,
	parameter int         TAC3_QTR   = 0,
	parameter int         TRP_NS     = 20,
	parameter int         TRRD_NS    = 20,
	parameter int         TRCD_NS    = 20
) (
	// clock and reset
	input  wire logic       CLOCK_I,
	input  wire logic       NRST_I,
	// two-wire serial pins, data is open drain
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE_O,
	// device address straps
	input  wire logic [2:0] SA_I,
	// status
	output logic            BUSY_O
);

	// ************************************************************
	// encoded table contents
	// ************************************************************
	localparam logic [7:0] B_BURST = enc_burst(BURST_LENS, BURST_PAGE);  // [R1] [R2]
	localparam logic [7:0] B_BANKS = enc_ns(DEV_BANKS);                  // [R3]
	localparam logic [7:0] B_CL    = enc_mask7(COL_LAT);                 // [R4]
	localparam logic [7:0] B_CS    = enc_mask7(CS_LAT);                  // [R5]
	localparam logic [7:0] B_WE    = enc_mask7(WE_LAT);                  // [R6]
	localparam logic [7:0] B_MOD   = enc_mask7(MOD_FLAGS);               // [R7] [R8]
	localparam logic [7:0] B_DEV   = enc_devattr(DEV_FLAGS, UP_TOL_5, LO_TOL_5);  // [R9] [R10]
	localparam logic [7:0] B_TCK2  = enc_tenth(TCK2_NS, TCK2_TENTH);     // [R11] [R13]
	localparam logic [7:0] B_TAC2  = enc_tenth(TAC2_NS, TAC2_TENTH);     // [R12] [R13]
	localparam logic [7:0] B_TCK3  = enc_quarter(TCK3_NS, TCK3_QTR);     // [R14]
	localparam logic [7:0] B_TAC3  = enc_quarter(TAC3_NS, TAC3_QTR);     // [R15]
	localparam logic [7:0] B_TRP   = enc_ns(TRP_NS);                     // [R16]
	localparam logic [7:0] B_TRRD  = enc_ns(TRRD_NS);                    // [R17]
	localparam logic [7:0] B_TRCD  = enc_ns(TRCD_NS);                    // [R18]

	localparam logic [BYTE_COUNT*8-1:0] ROM_INIT = {
		B_TRCD, B_TRRD, B_TRP, B_TAC3, B_TCK3, B_TAC2, B_TCK2,
		B_DEV, B_MOD, B_WE, B_CS, B_CL, B_BANKS, B_BURST
	};

	// ************************************************************
	// pin synchronisation
	// ************************************************************
	logic [4:0] pins_s;
	logic       scl_s;
	logic       sda_s;
	logic [2:0] sa_s;

	smar_sync #(
		.W       (5)
	) u_sync (
		.clk_i   (CLOCK_I),
		.rst_n_i (NRST_I),
		.d_i     ({SA_I, SCL_I, SDA_I}),
		.q_o     (pins_s)
	);

	assign sa_s  = pins_s[4:2];
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// ************************************************************
	// attribute store
	// ************************************************************
	smar_rom_if rom_if ();

	smar_rom #(
		.DEPTH   (BYTE_COUNT),
		.BASE    (OFS_BURST),
		.INIT    (ROM_INIT)
	) u_rom (
		.clk_i   (CLOCK_I),
		.rst_n_i (NRST_I),
		.rom     (rom_if)
	);

	// ************************************************************
	// state
	// ************************************************************
	smar_state_t state_q;
	smar_state_t state_d;
	smar_kind_t  kind_q;
	smar_kind_t  kind_d;
	logic        scl_p_q;
	logic        sda_p_q;
	logic [3:0]  cnt_q;
	logic [3:0]  cnt_d;
	logic [7:0]  sh_q;
	logic [7:0]  sh_d;
	logic [7:0]  tx_q;
	logic [7:0]  tx_d;
	logic [7:0]  ptr_q;
	logic [7:0]  ptr_d;
	logic        rw_q;
	logic        rw_d;
	logic        oe_q;
	logic        oe_d;
	logic        mack_q;
	logic        mack_d;
	logic        busy_q;
	logic        sda_o_q;

	// ************************************************************
	// bus event decode
	// ************************************************************
	logic       rise_w;
	logic       fall_w;
	logic       start_w;
	logic       stop_w;
	logic       byte_done_w;
	logic       addr_match_w;
	logic [7:0] ptr_inc_w;
	logic [3:0] cnt_inc_w;
	logic       read_go_w;

	// our own drive only changes while clock is low, so it never fakes a start or stop
	assign rise_w       = scl_s & ~scl_p_q;
	assign fall_w       = ~scl_s & scl_p_q;
	assign start_w      = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_w       = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign byte_done_w  = (cnt_q == BITS_PER_BYTE);
	assign addr_match_w = (sh_q[7:1] == {DEV_TYPE, sa_s});
	assign ptr_inc_w    = ptr_q + 8'h01;
	assign cnt_inc_w    = cnt_q + 4'h1;
	assign read_go_w    = (kind_q == K_ADDR) & rw_q;
	assign rom_if.offset = ptr_q;

	// ************************************************************
	// transfer sequencer
	// ************************************************************
	always_comb begin
		state_d = state_q;
		kind_d  = kind_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		tx_d    = tx_q;
		ptr_d   = ptr_q;
		rw_d    = rw_q;
		oe_d    = oe_q;
		mack_d  = mack_q;
		if (stop_w) begin
			state_d = ST_IDLE;
			oe_d    = 1'h0;
		end else if (start_w) begin
			state_d = ST_RX;
			kind_d  = K_ADDR;
			cnt_d   = 4'h0;
			oe_d    = 1'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					oe_d = 1'h0;
				end
				ST_RX: begin
					if (rise_w) begin
						sh_d  = {sh_q[6:0], sda_s};
						cnt_d = cnt_inc_w;
					end else if (fall_w && byte_done_w) begin
						cnt_d = 4'h0;
						case (kind_q)
							K_ADDR: begin
								if (addr_match_w) begin
									rw_d    = sh_q[0];
									oe_d    = 1'h1;
									state_d = ST_ACK;
								end else begin
									state_d = ST_IDLE;
								end
							end
							K_WORD: begin
								ptr_d   = sh_q;
								oe_d    = 1'h1;
								state_d = ST_ACK;
							end
							default: begin
								// data is acknowledged and dropped, only the pointer moves
								ptr_d   = ptr_inc_w;                        // [R20]
								oe_d    = 1'h1;
								state_d = ST_ACK;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (fall_w) begin
						cnt_d = 4'h0;
						if (read_go_w) begin
							tx_d    = rom_if.data;                      // [R20]
							oe_d    = ~rom_if.data[7];
							state_d = ST_TX;
						end else begin
							oe_d    = 1'h0;
							kind_d  = (kind_q == K_ADDR) ? K_WORD : K_DATA;
							state_d = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (rise_w) begin
						cnt_d = cnt_inc_w;
					end else if (fall_w) begin
						if (byte_done_w) begin
							oe_d    = 1'h0;
							ptr_d   = ptr_inc_w;
							mack_d  = 1'h0;
							state_d = ST_MACK;
						end else begin
							tx_d = {tx_q[6:0], 1'h0};
							oe_d = ~tx_q[6];
						end
					end
				end
				ST_MACK: begin
					if (rise_w) begin
						mack_d = ~sda_s;
					end else if (fall_w) begin
						cnt_d = 4'h0;
						if (mack_q) begin
							tx_d    = rom_if.data;                      // [R20]
							oe_d    = ~rom_if.data[7];
							state_d = ST_TX;
						end else begin
							state_d = ST_IDLE;
						end
					end
				end
				default: begin
					state_d = ST_IDLE;
					oe_d    = 1'h0;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state_q <= ST_IDLE;
			kind_q  <= K_ADDR;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			tx_q    <= 8'h00;
			ptr_q   <= 8'h00;
			rw_q    <= 1'h0;
			oe_q    <= 1'h0;
			mack_q  <= 1'h0;
		end else begin
			state_q <= state_d;
			kind_q  <= kind_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			tx_q    <= tx_d;
			ptr_q   <= ptr_d;
			rw_q    <= rw_d;
			oe_q    <= oe_d;
			mack_q  <= mack_d;
		end
	end

	// ************************************************************
	// pin and status registers
	// ************************************************************
	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			scl_p_q <= 1'h1;
			sda_p_q <= 1'h1;
			busy_q  <= 1'h0;
			sda_o_q <= 1'h0;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			busy_q  <= (state_d != ST_IDLE);
			sda_o_q <= 1'h0;
		end
	end

	assign SDA_O    = sda_o_q;
	assign SDA_OE_O = oe_q;
	assign BUSY_O   = busy_q;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!NRST_I);

	sequence seq_read_load;
		(state_q == ST_ACK) && fall_w && read_go_w && !start_w && !stop_w;
	endsequence

	sequence seq_write_drop;
		(state_q == ST_RX) && (kind_q == K_DATA) && fall_w && byte_done_w && !start_w && !stop_w;
	endsequence

	burst_value_a: assert property (                                             // [R1]
		(rom_if.offset == OFS_BURST) |-> (rom_if.data[3:0] == BURST_LENS) && (rom_if.data[7] == BURST_PAGE))
		else $error("burst support byte differs from supported lengths");

	burst_reserved_a: assert property (                                          // [R2]
		(rom_if.offset == OFS_BURST) |-> (rom_if.data[6:4] == 3'h0))
		else $error("burst support bits 6 to 4 not zero");

	bank_valid_a: assert property (                                              // [R3]
		(rom_if.offset == OFS_BANKS) |-> (rom_if.data != 8'h00))
		else $error("reserved bank count read back");

	module_top_a: assert property (                                              // [R7]
		(rom_if.offset == OFS_MODULE) |-> !rom_if.data[7])
		else $error("module attribute bit 7 set");

	comp_top_a: assert property (                                                // [R9]
		(rom_if.offset == OFS_COMPONENT) |-> (rom_if.data[7:6] == 2'h0))
		else $error("component attribute bits 7 and 6 set");

	tolerance_bits_a: assert property (                                          // [R10]
		(rom_if.offset == OFS_COMPONENT) |-> (rom_if.data[5] == UP_TOL_5) && (rom_if.data[4] == LO_TOL_5))
		else $error("supply tolerance flags misplaced");

	tenth_range_a: assert property (                                             // [R11]
		((rom_if.offset == OFS_TCK2) || (rom_if.offset == OFS_TAC2)) |-> (rom_if.data[3:0] <= 4'h9))
		else $error("tenths nibble above nine");

	rollup_code_a: assert property (                                             // [R13]
		((rom_if.offset == OFS_TCK2) && (TCK2_NS >= ROLLUP_LO) && (TCK2_NS <= ROLLUP_HI))
		|-> (rom_if.data[7:4] == 4'(TCK2_NS - ROLLUP_BASE)))
		else $error("long clock period not folded onto low codes");

	read_load_a: assert property (                                               // [R20]
		seq_read_load |=> (tx_q == $past(rom_if.data)) && (state_q == ST_TX) && (oe_q == !tx_q[7]))
		else $error("read byte not loaded unchanged");

	bit_order_a: assert property (                                               // [R20]
		(state_q == ST_TX) && fall_w && !byte_done_w && !start_w && !stop_w
		|=> (tx_q == {$past(tx_q[6:0]), 1'h0}) && (oe_q == !$past(tx_q[6])))
		else $error("read byte not shifted out msb first");

	write_drop_a: assert property (                                              // [R20]
		seq_write_drop |=> (state_q == ST_ACK) && oe_q && (ptr_q == $past(ptr_inc_w)) && (kind_q == K_DATA))
		else $error("written byte not acknowledged and ignored");

	release_stop_a: assert property (
		stop_w |=> !oe_q ##1 !oe_q)
		else $error("data line still driven after stop");

endmodule : smar_top

// [dv/smar_host.sv]
// host model that reads the attribute store over the two-wire serial path
`timescale 1ns/10ps
module smar_host #(
	parameter int HALF = 10
) (
	// clock and resolved data line
	input  wire logic clk_i,
	input  wire logic sda_i,
	// driven pins, data is open drain
	output logic      scl_o,
	output logic      sda_low_o
);
	initial begin
		scl_o     = 1'h1;
		sda_low_o = 1'h0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_clk

	// scl low on entry and exit; data moves two clocks after the fall
	task automatic put_bit(input logic b, output logic seen);
		wait_clk(2);
		sda_low_o <= ~b;
		wait_clk(HALF - 2);
		scl_o <= 1'h1;
		wait_clk(HALF - 1);
		@(negedge clk_i);
		seen = sda_i;
		@(posedge clk_i);
		scl_o <= 1'h0;
	endtask : put_bit

	// also serves as repeated start: releases the data line two clocks after the fall, before raising the clock
	task automatic start;
		wait_clk(2);
		sda_low_o <= 1'h0;
		wait_clk(HALF - 2);
		scl_o <= 1'h1;
		wait_clk(HALF);
		sda_low_o <= 1'h1;
		wait_clk(HALF);
		scl_o <= 1'h0;
	endtask : start

	task automatic stop;
		wait_clk(2);
		sda_low_o <= 1'h1;
		wait_clk(HALF - 2);
		scl_o <= 1'h1;
		wait_clk(HALF);
		sda_low_o <= 1'h0;
		wait_clk(HALF);
	endtask : stop

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], s);
		end
		put_bit(1'h1, s);
		ack = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 0; i < 8; i++) begin
			put_bit(1'h1, s);
			d = {d[6:0], s};
		end
		put_bit(~ack, s);
	endtask : recv_byte
endmodule : smar_host

// [dv/smar_top_tb.sv]
// self-checking bench for the module attribute store
`timescale 1ns/10ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
	$display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module smar_top_tb import smar_pkg::*;;
	// ************************************************************
	// clock, pins and expected table
	// ************************************************************
	logic       CLOCK_I;
	logic       NRST_I;
	logic [2:0] SA_I;
	logic       SDA_O;
	logic       SDA_OE_O;
	logic       BUSY_O;
	logic       scl;
	logic       host_low;
	wire logic  sda = ~(SDA_OE_O | host_low);
	int         miscompares;
	int         n_compared;
	logic [7:0] rx [16];
	localparam logic [2:0] SA = 3'h5;
	// defaults, plus module flags 55, upper tolerance 5 percent, 17.5 ns rolled to code 2, 63 ns quarter format
	localparam logic [7:0] EXP [14] = '{8'h8F, 8'h04, 8'h06, 8'h01, 8'h01, 8'h55, 8'h2E,
		8'h25, 8'h90, 8'hFC, 8'h00, 8'h14, 8'h14, 8'h14};

	// only fields whose encodings are not plain binary move off their defaults
	smar_top #(.MOD_FLAGS(7'h55), .UP_TOL_5(1'h1), .TCK2_NS(17), .TCK2_TENTH(5), .TCK3_NS(63)) smar_top_i (
		.CLOCK_I (CLOCK_I),
		.NRST_I  (NRST_I),
		.SCL_I   (scl),
		.SDA_I   (sda),
		.SDA_O   (SDA_O),
		.SDA_OE_O(SDA_OE_O),
		.SA_I    (SA_I),
		.BUSY_O  (BUSY_O)
	);

	smar_host smar_host_i (
		.clk_i    (CLOCK_I),
		.sda_i    (sda),
		.scl_o    (scl),
		.sda_low_o(host_low)
	);

	initial begin
		CLOCK_I = 1'h0;
		forever #25 CLOCK_I = ~CLOCK_I;
	end

	// ************************************************************
	// shared transfers
	// ************************************************************
	task automatic addr(input logic [2:0] sa, input logic rd, input logic want);
		logic a;
		smar_host_i.send_byte({DEV_TYPE, sa, rd}, a);
		`CHK("address ack", want, a)
	endtask : addr

	task automatic read_at(input logic [7:0] ofs, input int n);
		logic a;
		smar_host_i.start();
		addr(SA, 1'h0, 1'h1);
		smar_host_i.send_byte(ofs, a);
		smar_host_i.start();
		addr(SA, 1'h1, 1'h1);
		`CHK("busy in read", 1'h1, BUSY_O)
		for (int i = 0; i < n; i++) begin
			smar_host_i.recv_byte(i < n - 1, rx[i]);
		end
		smar_host_i.stop();
		`CHK("data line drive", 1'h0, SDA_O)
	endtask : read_at

	task automatic stop_test;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_each_byte;
		for (int i = 0; i < 14; i++) begin
			read_at(OFS_BURST + 8'(i), 1);
			// tolerance bits give the supply range the host applies to the timings
			if (i < 7) `CHK("flag byte", EXP[i], rx[0])
			else `CHK("timing byte", EXP[i], rx[0])
		end
	endtask : t_each_byte

	// sequential read from one below the table to one past it
	task automatic t_sequential;
		read_at(8'h0F, 16);
		`CHK("below table", UNMAPPED_VALUE, rx[0])
		for (int i = 0; i < 14; i++) begin
			`CHK("sequential byte", EXP[i], rx[i + 1])
		end
		`CHK("past table", UNMAPPED_VALUE, rx[15])
	endtask : t_sequential

	// writes are taken but leave the bytes alone; the pointer still moves
	task automatic t_write;
		logic a;
		smar_host_i.start();
		addr(SA, 1'h0, 1'h1);
		smar_host_i.send_byte(OFS_COL_LAT, a);
		smar_host_i.send_byte(8'hA5, a);
		`CHK("write data ack", 1'h1, a)
		smar_host_i.send_byte(8'h5A, a);
		smar_host_i.start();
		addr(SA, 1'h1, 1'h1);
		smar_host_i.recv_byte(1'h0, rx[0]);
		smar_host_i.stop();
		`CHK("current read", EXP[4], rx[0])
		read_at(OFS_COL_LAT, 2);
		`CHK("written column byte", EXP[2], rx[0])
		`CHK("written select byte", EXP[3], rx[1])
	endtask : t_write

	// another device address is ignored, so its write cannot land
	task automatic t_other_device;
		logic a;
		smar_host_i.start();
		addr(3'h2, 1'h0, 1'h0);
		smar_host_i.send_byte(OFS_BURST, a);
		smar_host_i.send_byte(8'h00, a);
		smar_host_i.stop();
		`CHK("idle after foreign address", 1'h0, BUSY_O)
		read_at(OFS_BURST, 1);
		`CHK("burst byte kept", EXP[0], rx[0])
	endtask : t_other_device

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		miscompares = 0;
		n_compared  = 0;
		NRST_I      = 1'h0;
		SA_I        = SA;
		repeat (12) @(posedge CLOCK_I);
		NRST_I <= 1'h1;
		repeat (6) @(posedge CLOCK_I);
		t_each_byte();
		t_sequential();
		t_write();
		t_other_device();
		stop_test();
	end

	// the tests need about 18400 cycles; allow over four times that
	initial begin
		repeat (80000) @(posedge CLOCK_I);
		miscompares++;
		stop_test();
	end
endmodule : smar_top_tb
